// >>> hdl/spb_pkg.sv
//==============================================================================
// spb_pkg
//==============================================================================
// Purpose: shared constants and types for the serial port with parity and baud
// Assumes: 8-bit register port, 3-bit register index
// Notes:   flag positions are shared by status register and irq enables
package spb_pkg;
    // register map
    localparam logic [2:0] ADDR_DATA   = 3'h0;
    localparam logic [2:0] ADDR_STATUS = 3'h1;
    localparam logic [2:0] ADDR_CTRL1  = 3'h2;
    localparam logic [2:0] ADDR_CTRL2  = 3'h3;
    localparam logic [2:0] ADDR_BAUD   = 3'h4;
    localparam logic [2:0] ADDR_TXFINE = 3'h5;
    localparam logic [2:0] ADDR_RXFINE = 3'h6;
    // control one fields
    localparam int C1_T8   = 7;
    localparam int C1_R8   = 6;
    localparam int C1_M    = 4;
    localparam int C1_WAKE = 3;
    localparam int C1_PCE  = 2;
    localparam int C1_PS   = 1;
    localparam int C1_PIE  = 0;
    // control two fields
    localparam int C2_TIE  = 7;
    localparam int C2_TX_COMPLETE_IRQ_ENABLE = 6;
    localparam int C2_RIE  = 5;
    localparam int C2_IDLE_IRQ_ENABLE = 4;
    localparam int C2_TE   = 3;
    localparam int C2_RE   = 2;
    localparam int C2_RWU  = 1;
    // status / event flag positions
    localparam int F_TX_BUFFER_EMPTY_FLAG = 7;
    localparam int F_TC   = 6;
    localparam int F_RX_READY_FLAG = 5;
    localparam int F_IDLE = 4;
    localparam int F_OR   = 3;
    localparam int F_PE   = 0;
    // baud register fields
    localparam int BR_SCP_HI = 7;
    localparam int BR_SCP_LO = 6;
    localparam int BR_SCT_HI = 5;
    localparam int BR_SCT_LO = 3;
    localparam int BR_SCR_HI = 2;
    localparam int BR_SCR_LO = 0;
    // reset values
    localparam logic [7:0] BAUD_RST   = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'hc0;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    // prescaler factors for codes 00..11
    localparam logic [3:0] PR_F0 = 4'h1;
    localparam logic [3:0] PR_F1 = 4'h3;
    localparam logic [3:0] PR_F2 = 4'h4;
    localparam logic [3:0] PR_F3 = 4'hd;
    // oversampling
    localparam logic [3:0] OS_LAST = 4'hf;
    localparam logic [3:0] OS_MID  = 4'h7;
    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} spb_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spb_rx_state_t;
endpackage

// >>> hdl/spb_uart.sv
//==============================================================================
// spb_uart
//==============================================================================
// Purpose: async serial port with parity, split data buffer, baud and events
// Assumes: 16x oversampled bit timing, inputs synchronous to clk_sys_i
// Notes:   halt freezes all state except rdata_o, irq_o and wake_o; wait leaves it running
`timescale 1ns/1ps

module spb_uart (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       rxd_i,
    output logic            txd_o,
    input  wire logic       cpu_int_mask_i,
    input  wire logic       wait_mode_i,
    input  wire logic       halt_mode_i,
    output logic            irq_o,
    output logic            wake_o
);
    //==========================================================================
    // registers and helpers
    //==========================================================================
    logic [7:0]              ctrl1;
    logic [7:0]              ctrl2;
    logic [7:0]              baud;
    logic [7:0]              tx_fine;
    logic [7:0]              rx_fine;
    logic [7:0]              status;
    logic [7:0]              tx_hold;
    logic [7:0]              rx_hold;
    logic                    rx_bit8;
    logic                    tx_full;
    logic                    status_seen;
    logic                    run;
    logic                    rx_mute;
    logic                    tx_load;
    logic                    wr_data;
    logic                    rd_data;
    logic [7:0]              ev_en;
    spb_pkg::spb_tx_state_t  tx_state;
    spb_pkg::spb_rx_state_t  rx_state;

    assign run     = !halt_mode_i;
    assign wr_data = run && wr_i && addr_i == spb_pkg::ADDR_DATA;
    assign rd_data = run && rd_i && addr_i == spb_pkg::ADDR_DATA;

    // parity bit over 7 or 8 low bits
    function automatic logic par_of(input logic [8:0] d, input logic m, input logic odd);
        par_of = (m ? ^d[7:0] : ^d[6:0]) ^ odd;
    endfunction

    // total division from prescaler, divisor code and fine factor
    function automatic logic [23:0] div_of(input logic [1:0] first_prescaler_field, input logic [2:0] code,
                                           input logic [7:0] fine);
        logic [23:0] pr;
        logic [23:0] base;
        case (first_prescaler_field)
            2'h0:    pr = 24'(spb_pkg::PR_F0);
            2'h1:    pr = 24'(spb_pkg::PR_F1);
            2'h2:    pr = 24'(spb_pkg::PR_F2);
            default: pr = 24'(spb_pkg::PR_F3);
        endcase
        base = pr << code;
        div_of = (fine == 8'h00) ? base : 24'(base * 24'(fine));
    endfunction

    //==========================================================================
    // register port
    //==========================================================================
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl1   <= spb_pkg::CTRL_RST;
            ctrl2   <= spb_pkg::CTRL_RST;
            baud    <= spb_pkg::BAUD_RST;
            tx_fine <= 8'h00;
            rx_fine <= 8'h00;
        end else if (run && wr_i) begin
            case (addr_i)
                spb_pkg::ADDR_CTRL1:  ctrl1[7] <= wdata_i[spb_pkg::C1_T8];
                spb_pkg::ADDR_BAUD:   baud     <= wdata_i;
                spb_pkg::ADDR_TXFINE: tx_fine  <= wdata_i;
                spb_pkg::ADDR_RXFINE: rx_fine  <= wdata_i;
                default: ;
            endcase
            if (addr_i == spb_pkg::ADDR_CTRL1)
                ctrl1[5:0] <= wdata_i[5:0];
            if (addr_i == spb_pkg::ADDR_CTRL2)
                ctrl2[7:2] <= wdata_i[7:2];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                spb_pkg::ADDR_DATA:   rdata_o <= rx_hold;
                spb_pkg::ADDR_STATUS: rdata_o <= status;
                spb_pkg::ADDR_CTRL1:  rdata_o <= {ctrl1[7], rx_bit8, ctrl1[5:0]};
                spb_pkg::ADDR_CTRL2:  rdata_o <= {ctrl2[7:2], rx_mute, 1'b0};
                spb_pkg::ADDR_BAUD:   rdata_o <= baud;
                spb_pkg::ADDR_TXFINE: rdata_o <= tx_fine;
                spb_pkg::ADDR_RXFINE: rdata_o <= rx_fine;
                default:              rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // status read arms the clearing sequence
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i)
            status_seen <= 1'b0;
        else if (run && rd_i && addr_i == spb_pkg::ADDR_STATUS)
            status_seen <= 1'b1;
        else if (wr_data || rd_data)
            status_seen <= 1'b0;
    end

    //==========================================================================
    // rate generators, 16 ticks per bit
    //==========================================================================
    logic [23:0] tx_div;
    logic [23:0] rx_div;
    logic [23:0] tx_rate_cnt;
    logic [23:0] rx_rate_cnt;
    logic        tx_os;
    logic        rx_os;

    assign tx_div = div_of(baud[spb_pkg::BR_SCP_HI:spb_pkg::BR_SCP_LO],
                           baud[spb_pkg::BR_SCT_HI:spb_pkg::BR_SCT_LO], tx_fine);
    assign rx_div = div_of(baud[spb_pkg::BR_SCP_HI:spb_pkg::BR_SCP_LO],
                           baud[spb_pkg::BR_SCR_HI:spb_pkg::BR_SCR_LO], rx_fine);
    assign tx_os  = run && tx_rate_cnt >= tx_div - 24'h1;
    assign rx_os  = run && rx_rate_cnt >= rx_div - 24'h1;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i)
            tx_rate_cnt <= 24'h0;
        else if (run)
            // restart at load so the start bit gets its full length
            tx_rate_cnt <= (tx_os || tx_load) ? 24'h0 : tx_rate_cnt + 24'h1;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i)
            rx_rate_cnt <= 24'h0;
        else if (run)
            rx_rate_cnt <= rx_os ? 24'h0 : rx_rate_cnt + 24'h1;
    end

    //==========================================================================
    // transmitter
    //==========================================================================
    logic [10:0] tx_shift;
    logic [3:0]  tx_os_cnt;
    logic [3:0]  tx_bits;
    logic [8:0]  tx_word;
    logic        tx_last;

    always_comb begin
        tx_word = {ctrl1[spb_pkg::C1_T8], tx_hold};
        if (ctrl1[spb_pkg::C1_PCE]) begin
            if (ctrl1[spb_pkg::C1_M])
                tx_word[8] = par_of(tx_word, 1'b1, ctrl1[spb_pkg::C1_PS]);
            else
                tx_word[7] = par_of(tx_word, 1'b0, ctrl1[spb_pkg::C1_PS]);
        end
    end

    assign tx_load = run && tx_state == spb_pkg::TX_IDLE && tx_full && ctrl2[spb_pkg::C2_TE];
    assign tx_last = tx_os && tx_os_cnt == spb_pkg::OS_LAST
                     && tx_bits == (ctrl1[spb_pkg::C1_M] ? 4'ha : 4'h9);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_state  <= spb_pkg::TX_IDLE;
            tx_shift  <= 11'h7ff;
            tx_os_cnt <= 4'h0;
            tx_bits   <= 4'h0;
        end else if (tx_load) begin
            tx_state  <= spb_pkg::TX_SHIFT;
            tx_shift  <= ctrl1[spb_pkg::C1_M] ? {1'b1, tx_word, 1'b0}
                                              : {2'b11, tx_word[7:0], 1'b0};
            tx_os_cnt <= 4'h0;
            tx_bits   <= 4'h0;
        end else if (tx_state == spb_pkg::TX_SHIFT && tx_os) begin
            tx_os_cnt <= tx_os_cnt + 4'h1;
            if (tx_os_cnt == spb_pkg::OS_LAST) begin
                tx_shift <= {1'b1, tx_shift[10:1]};
                tx_bits  <= tx_bits + 4'h1;
                if (tx_last)
                    tx_state <= spb_pkg::TX_IDLE;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i)
            txd_o <= 1'b1;
        else if (run)
            txd_o <= (tx_state == spb_pkg::TX_SHIFT) ? tx_shift[0] : 1'b1;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_hold <= 8'h00;
            tx_full <= 1'b0;
        end else if (wr_data) begin
            tx_hold <= wdata_i;
            tx_full <= 1'b1;
        end else if (tx_load) begin
            tx_full <= 1'b0;
        end
    end

    //==========================================================================
    // receiver
    //==========================================================================
    logic [8:0] rx_shift;
    logic [8:0] rx_word;
    logic [3:0] rx_os_cnt;
    logic [3:0] rx_bits;
    logic [3:0] idle_bits;
    logic       idle_armed;
    logic       rx_done;
    logic       rx_msb;
    logic       rx_accept;
    logic       rx_bad_par;

    assign rx_word    = ctrl1[spb_pkg::C1_M] ? rx_shift : {1'b0, rx_shift[8:1]};
    assign rx_msb     = ctrl1[spb_pkg::C1_M] ? rx_word[8] : rx_word[7];
    assign rx_done    = rx_state == spb_pkg::RX_STOP && rx_os && rx_os_cnt == spb_pkg::OS_MID;
    assign rx_accept  = rx_done && (!rx_mute || rx_msb);
    assign rx_bad_par = ctrl1[spb_pkg::C1_PCE] && par_of(rx_word, ctrl1[spb_pkg::C1_M],
                        ctrl1[spb_pkg::C1_PS]) != rx_msb;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_state  <= spb_pkg::RX_IDLE;
            rx_os_cnt <= 4'h0;
            rx_bits   <= 4'h0;
            rx_shift  <= 9'h000;
        end else if (rx_os && ctrl2[spb_pkg::C2_RE]) begin
            rx_os_cnt <= rx_os_cnt + 4'h1;
            case (rx_state)
                spb_pkg::RX_IDLE: begin
                    // tick count keeps running so idle bit times are counted
                    if (!rxd_i) begin
                        rx_state  <= spb_pkg::RX_START;
                        rx_os_cnt <= 4'h0;
                    end
                end
                spb_pkg::RX_START: begin
                    if (rx_os_cnt == spb_pkg::OS_MID) begin
                        rx_state  <= rxd_i ? spb_pkg::RX_IDLE : spb_pkg::RX_DATA;
                        rx_os_cnt <= spb_pkg::OS_MID + 4'h1;
                        rx_bits   <= 4'h0;
                    end
                end
                spb_pkg::RX_DATA: begin
                    if (rx_os_cnt == spb_pkg::OS_MID) begin
                        rx_shift <= {rxd_i, rx_shift[8:1]};
                        rx_bits  <= rx_bits + 4'h1;
                        if (rx_bits == (ctrl1[spb_pkg::C1_M] ? 4'h8 : 4'h7))
                            rx_state <= spb_pkg::RX_STOP;
                    end
                end
                spb_pkg::RX_STOP: begin
                    if (rx_os_cnt == spb_pkg::OS_MID)
                        rx_state <= spb_pkg::RX_IDLE;
                end
                default: rx_state <= spb_pkg::RX_IDLE;
            endcase
        end
    end

    // receive buffer, kept while a previous word is unread
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_hold <= 8'h00;
            rx_bit8 <= 1'b0;
        end else if (rx_accept && !status[spb_pkg::F_RX_READY_FLAG]) begin
            rx_hold <= rx_word[7:0];
            rx_bit8 <= rx_word[8];
        end
    end

    // mute until an address mark arrives
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i)
            rx_mute <= 1'b0;
        else if (rx_done && rx_mute && rx_msb)
            rx_mute <= 1'b0;
        else if (run && wr_i && addr_i == spb_pkg::ADDR_CTRL2 && ctrl1[spb_pkg::C1_WAKE])
            rx_mute <= wdata_i[spb_pkg::C2_RWU];
    end

    // idle: a whole frame of ones after a word
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idle_armed <= 1'b0;
            idle_bits  <= 4'h0;
        end else if (rx_accept) begin
            idle_armed <= 1'b1;
            idle_bits  <= 4'h0;
        end else if (rx_os && rx_os_cnt == spb_pkg::OS_LAST) begin
            idle_bits <= (rxd_i && rx_state == spb_pkg::RX_IDLE) ? idle_bits + 4'h1 : 4'h0;
            if (idle_bits == (ctrl1[spb_pkg::C1_M] ? 4'ha : 4'h9))
                idle_armed <= 1'b0;
        end
    end

    //==========================================================================
    // event flags; a set in the clearing cycle wins
    //==========================================================================
    logic [7:0] ev_set;
    logic [7:0] ev_clr;
    logic       idle_hit;

    assign idle_hit = idle_armed && rx_os && rx_os_cnt == spb_pkg::OS_LAST && rxd_i
                      && rx_state == spb_pkg::RX_IDLE
                      && idle_bits == (ctrl1[spb_pkg::C1_M] ? 4'ha : 4'h9);

    always_comb begin
        ev_set = 8'h00;
        ev_set[spb_pkg::F_TX_BUFFER_EMPTY_FLAG] = tx_load;
        ev_set[spb_pkg::F_TC]   = tx_last && !tx_full;
        ev_set[spb_pkg::F_RX_READY_FLAG] = rx_accept && !status[spb_pkg::F_RX_READY_FLAG];
        ev_set[spb_pkg::F_OR]   = rx_accept && status[spb_pkg::F_RX_READY_FLAG];
        ev_set[spb_pkg::F_IDLE] = idle_hit;
        ev_set[spb_pkg::F_PE]   = rx_accept && rx_bad_par;
        ev_clr = 8'h00;
        if (status_seen && wr_data) begin
            ev_clr[spb_pkg::F_TX_BUFFER_EMPTY_FLAG] = 1'b1;
            ev_clr[spb_pkg::F_TC]   = 1'b1;
        end
        if (status_seen && rd_data) begin
            ev_clr[spb_pkg::F_RX_READY_FLAG] = 1'b1;
            ev_clr[spb_pkg::F_OR]   = 1'b1;
            ev_clr[spb_pkg::F_IDLE] = 1'b1;
            ev_clr[spb_pkg::F_PE]   = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i)
            status <= spb_pkg::STATUS_RST;
        else
            status <= ev_set | (status & ~ev_clr);
    end

    //==========================================================================
    // interrupt and wake
    //==========================================================================
    always_comb begin
        ev_en = 8'h00;
        ev_en[spb_pkg::F_TX_BUFFER_EMPTY_FLAG] = ctrl2[spb_pkg::C2_TIE];
        ev_en[spb_pkg::F_TC]   = ctrl2[spb_pkg::C2_TX_COMPLETE_IRQ_ENABLE];
        ev_en[spb_pkg::F_RX_READY_FLAG] = ctrl2[spb_pkg::C2_RIE];
        ev_en[spb_pkg::F_OR]   = ctrl2[spb_pkg::C2_RIE];
        ev_en[spb_pkg::F_IDLE] = ctrl2[spb_pkg::C2_IDLE_IRQ_ENABLE];
        ev_en[spb_pkg::F_PE]   = ctrl1[spb_pkg::C1_PIE];
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o  <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            irq_o  <= |(status & ev_en) && !cpu_int_mask_i;
            wake_o <= |(status & ev_en) && wait_mode_i && !halt_mode_i;
        end
    end

    //==========================================================================
    // checks
    //==========================================================================
    property p_even_tx;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (tx_load && ctrl1[spb_pkg::C1_PCE] && !ctrl1[spb_pkg::C1_PS] && !ctrl1[spb_pkg::C1_M])
        |=> (^tx_shift[8:1]) == 1'b0;
    endproperty
    a_even_tx: assert property (p_even_tx) else $error("even parity frame wrong");

    property p_odd_tx;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (tx_load && ctrl1[spb_pkg::C1_PCE] && ctrl1[spb_pkg::C1_PS])
        |=> (ctrl1[spb_pkg::C1_M] ? ^tx_shift[9:1] : ^tx_shift[8:1]) == 1'b1;
    endproperty
    a_odd_tx: assert property (p_odd_tx) else $error("odd parity frame wrong");

    property p_pe_set;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (rx_accept && rx_bad_par) |=> status[spb_pkg::F_PE];
    endproperty
    a_pe_set: assert property (p_pe_set) else $error("parity error not flagged");

    property p_halt_freeze;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        halt_mode_i ##1 halt_mode_i |-> $stable(txd_o) && $stable(tx_rate_cnt);
    endproperty
    a_halt_freeze: assert property (p_halt_freeze) else $error("activity in halt");

    property p_irq;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (|(status & ev_en)) && !cpu_int_mask_i |=> irq_o ##0 $past(status) != 8'h00;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_irq_mask;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        cpu_int_mask_i |=> !irq_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");

    property p_wake;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wake_o |-> $past(wait_mode_i) && !$past(halt_mode_i);
    endproperty
    a_wake: assert property (p_wake) else $error("bad wake");

    property p_seq_clear;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (status_seen && wr_data && !tx_load) |=> !status[spb_pkg::F_TX_BUFFER_EMPTY_FLAG]
        && status[spb_pkg::F_TC] == $past(ev_set[spb_pkg::F_TC]);
    endproperty
    a_seq_clear: assert property (p_seq_clear) else $error("tx flags not cleared");

    property p_split;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (wr_data && !rx_accept) |=> $stable(rx_hold) && tx_hold == $past(wdata_i);
    endproperty
    a_split: assert property (p_split) else $error("buffers not split");
endmodule // spb_uart

// >>> bench/spb_node.sv
//==============================================================================
// spb_node
//==============================================================================
// Purpose: remote serial node facing spb_uart
// Assumes: 8N1 framing from the bench's view, line idles high
// Notes:   bit time given in clocks by the caller
`timescale 1ns/1ps
module spb_node (
    input  wire logic clk_sys_i,
    input  wire logic txd_i,
    output logic      rxd_o
);
    initial rxd_o = 1'b1;
    // start, eight bits lsb first, stop
    task automatic send(input logic [7:0] bits, input int bit_cyc);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys_i);
            rxd_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : bits[i-1];
            repeat (bit_cyc - 1) @(posedge clk_sys_i);
        end
    endtask
    // start bit width, then mid-cell samples, returns on idle line
    task automatic grab(input int bit_cyc, output logic [7:0] data, output int low_len);
        low_len = 0;
        data = 8'h00;
        for (int t = 0; t < 50000 && txd_i !== 1'b0; t++) begin
            @(posedge clk_sys_i);
            #1;
        end
        while (txd_i === 1'b0 && low_len < 50000) begin
            @(posedge clk_sys_i);
            #1;
            low_len++;
        end
        repeat (bit_cyc / 2) @(posedge clk_sys_i);
        for (int i = 0; i < 8; i++) begin
            data[i] = txd_i;
            repeat (bit_cyc) @(posedge clk_sys_i);
        end
        repeat (bit_cyc) @(posedge clk_sys_i);
    endtask
endmodule // spb_node

// >>> bench/spb_uart_tb.sv
//==============================================================================
// spb_uart_tb
//==============================================================================
// Purpose: self-checking register-level bench for spb_uart
// Assumes: spb_node on the serial lines
// Notes:   bit times kept short by the baud table
`timescale 1ns/1ps
module spb_uart_tb;
    logic       clk_sys_i, rst_n_i, wr_i, rd_i, rxd_i, txd_o;
    logic       cpu_int_mask_i, wait_mode_i, halt_mode_i, irq_o, wake_o;
    logic [2:0] addr_i;
    logic [7:0] wdata_i, rdata_o, d, e;
    int         n_errors = 0, comparisons = 0, n;
    logic [7:0] brt [6] = '{8'h00, 8'h40, 8'h80, 8'hc0, 8'h38, 8'h08};
    logic [7:0] fnt [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
    int         dvt [6] = '{1, 3, 4, 13, 128, 6};

    spb_uart i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i),
        .txd_o(txd_o), .cpu_int_mask_i(cpu_int_mask_i), .wait_mode_i(wait_mode_i),
        .halt_mode_i(halt_mode_i), .irq_o(irq_o), .wake_o(wake_o));
    spb_node i_node (.clk_sys_i(clk_sys_i), .txd_i(txd_o), .rxd_o(rxd_i));

    //==========================================================================
    // bus tasks and checks
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            n_errors++;
            $display("BAD %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    //==========================================================================
    // sequence
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        rst_n_i = 1'b0;
        {wr_i, rd_i, wait_mode_i, halt_mode_i} = 4'h0;
        cpu_int_mask_i = 1'b1;
        addr_i = 3'h0;
        wdata_i = 8'h00;
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(spb_pkg::ADDR_BAUD, d);
        chk(d, 8'h00);
        rd(spb_pkg::ADDR_STATUS, d);
        chk(d, spb_pkg::STATUS_RST);
        rd(3'h7, d);
        chk(d, 8'h00);
        halt_mode_i <= 1'b1;
        wr(spb_pkg::ADDR_BAUD, 8'h3f);
        halt_mode_i <= 1'b0;
        rd(spb_pkg::ADDR_BAUD, d);
        chk(d, 8'h00);
        wr(spb_pkg::ADDR_CTRL2, 8'h0c);
        for (int i = 0; i < 6; i++) begin
            wr(spb_pkg::ADDR_BAUD, brt[i]);
            wr(spb_pkg::ADDR_TXFINE, fnt[i]);
            wr(spb_pkg::ADDR_DATA, 8'h01);
            i_node.grab(16 * dvt[i], d, n);
            chk_n(n, 16 * dvt[i]);
            chk(d, 8'h01);
            if (n == 0) complete_run();
        end
        wr(spb_pkg::ADDR_BAUD, 8'h00);
        wr(spb_pkg::ADDR_TXFINE, 8'h00);
        for (int ps = 0; ps < 2; ps++) begin
            wr(spb_pkg::ADDR_CTRL1, 8'h04 | 8'(ps << 1));
            wr(spb_pkg::ADDR_DATA, 8'hb5);
            i_node.grab(16, d, n);
            e = {(^7'h35) ^ ps[0], 7'h35};
            chk(d, e);
        end
        wr(spb_pkg::ADDR_CTRL1, 8'h05);
        cpu_int_mask_i <= 1'b0;
        i_node.send(8'h4a, 16);
        repeat (4) @(posedge clk_sys_i);
        rd(spb_pkg::ADDR_STATUS, d);
        chk(d & 8'h21, 8'h21);
        chk({7'h00, irq_o}, 8'h01);
        cpu_int_mask_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        chk({7'h00, irq_o}, 8'h00);
        cpu_int_mask_i <= 1'b0;
        wr(spb_pkg::ADDR_CTRL2, 8'h2c);
        wait_mode_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        chk({7'h00, wake_o}, 8'h01);
        halt_mode_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        chk({7'h00, wake_o}, 8'h00);
        halt_mode_i <= 1'b0;
        rd(spb_pkg::ADDR_DATA, d);
        chk(d, 8'h4a);
        wr(spb_pkg::ADDR_BAUD, 8'h01);
        wr(spb_pkg::ADDR_RXFINE, 8'h03);
        i_node.send(8'h3c, 96);
        rd(spb_pkg::ADDR_STATUS, d);
        chk(d & 8'h29, 8'h20);
        rd(spb_pkg::ADDR_DATA, d);
        chk(d, 8'h3c);
        wr(spb_pkg::ADDR_CTRL1, 8'h08);
        wr(spb_pkg::ADDR_CTRL2, 8'h0e);
        i_node.send(8'h11, 96);
        i_node.send(8'h92, 96);
        rd(spb_pkg::ADDR_DATA, d);
        chk(d, 8'h92);
        repeat (1000) @(posedge clk_sys_i);
        rd(spb_pkg::ADDR_STATUS, d);
        chk(d & 8'h10, 8'h10);
        complete_run();
    end
endmodule // spb_uart_tb
